// file: inc/dacoc_pkg.sv
// Shared constants and types for the DAC output option control block
package dacoc_pkg;

   // Serial control word layout
   localparam int WORD_BITS = 16;
   localparam int WORD_ZERO_BIT = 15;
   localparam int IDX_MSB = 14;
   localparam int IDX_LSB = 8;

   // Register indices carried in the control word
   localparam logic [6:0] SOFT_RESET_IDX = 7'h12;
   localparam logic [6:0] FILTER_CTRL_IDX = 7'h14;
   localparam logic [6:0] OUTPUT_OPT_IDX = 7'h16;

   // Field positions
   localparam int SOFT_RESET_BIT = 7;
   localparam int FILTER_ROLLOFF_BIT = 5;
   localparam int ZERO_GROUP_BIT = 2;
   localparam int ZERO_POL_BIT = 1;
   localparam int PHASE_INV_BIT = 0;

   // Reset values of the option bits
   localparam logic FILTER_ROLLOFF_RESET = 1'b0;
   localparam logic PHASE_INV_RESET = 1'b0;
   localparam logic ZERO_POL_RESET = 1'b0;
   localparam logic ZERO_GROUP_RESET = 1'b0;

   // Timing: 64x oversampling tick derived from the system clock
   localparam int CLK_HZ = 50_000_000;
   localparam int FS_HZ = 48_000;
   localparam int OS_RATIO = 64;
   localparam int OS_DIV = CLK_HZ / (FS_HZ * OS_RATIO);
   localparam logic [7:0] OS_DIV_LAST = 8'(OS_DIV - 1);

   // Consecutive zero samples before a zero detect
   localparam logic [10:0] ZERO_RUN = 11'h400;

   // Sample and modulator widths
   localparam int SAMPLE_W = 24;
   localparam int ACC_W = 30;

   typedef struct packed {
      logic filter_rolloff_select;
      logic output_phase_invert;
      logic zero_flag_polarity;
      logic zero_flag_grouping;
   } dacoc_opt_t;

   localparam dacoc_opt_t OPT_RESET = '{FILTER_ROLLOFF_RESET, PHASE_INV_RESET,
                                        ZERO_POL_RESET, ZERO_GROUP_RESET};

   typedef enum logic [1:0] {
      SP_IDLE = 2'b01,
      SP_SHIFT = 2'b10
   } dacoc_sp_state_t;

endpackage : dacoc_pkg

// file: rtl/dacoc_modulator.sv
// Eight-level fourth-order delta-sigma modulator for one channel
`timescale 1ns/1ns
module dacoc_modulator
   import dacoc_pkg::*;
(
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst_n,
   // Oversampled input
   input wire logic os_tick,
   input wire logic invert,
   input wire logic signed [SAMPLE_W-1:0] din,
   // Quantizer level 0..7
   output logic [2:0] level
);

   logic signed [ACC_W-1:0] acc [4];
   logic signed [ACC_W-1:0] x_ext;
   logic signed [ACC_W-1:0] fb;
   logic signed [ACC_W-1:0] q;
   logic signed [3:0] lvl_s;
   logic [2:0] next_level;

   // Wider than the sample so negating full scale cannot wrap
   // Half scale in: full scale asks for two levels, leaving room for shaped noise
   always_comb
   begin
      x_ext = ACC_W'(din) >>> 1;
      if (invert)
         x_ext = -x_ext;
   end

   // Feedback is this tick's decision recentred to -4..3, one step per 2^21
   // Taken before the level flop: an extra loop delay makes the shaper unstable
   always_comb
   begin
      lvl_s = $signed({1'b0, next_level}) - 4'sd4;
      fb = {{5{lvl_s[3]}}, lvl_s, 21'h0};
   end

   // Four cascaded integrators, each fed back from the quantizer
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         for (int k = 0; k < 4; k++)
            acc[k] <= '0;
      end
      else if (os_tick)
      begin
         // Weights 1/4, 1, 3/2, 1 put all four noise poles at 0.75, gain below two
         acc[0] <= acc[0] + ((x_ext - fb) >>> 2);
         acc[1] <= acc[1] + (acc[0] >>> 2) - fb;
         acc[2] <= acc[2] + (acc[1] >>> 2) - fb - (fb >>> 1);
         acc[3] <= acc[3] + (acc[2] >>> 2) - fb;
      end
   end

   // Eight-level quantizer with clamping
   always_comb
   begin
      q = acc[3] >>> 21;
      if (q > 30'sd3)
         next_level = 3'h7;
      else if (q < -30'sd4)
         next_level = 3'h0;
      else
         next_level = q[2:0] + 3'h4;
   end

   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
         level <= 3'h4;
      else if (os_tick)
         level <= next_level;
   end

   property p_level_hold;
      @(posedge clk_sys) disable iff (!rst_n)
      !os_tick |=> $stable(level);
   endproperty
   a_level_hold: assert property (p_level_hold)
      else $error("Modulator level changed without an oversample tick");

   c_level_top: cover property (@(posedge clk_sys) disable iff (!rst_n) level == 3'h7);

endmodule : dacoc_modulator

// file: rtl/dacoc_top.sv
// DAC output option control: serial control port, options, zero flags, modulators
// Summary of operation
// - Filter bit 0 sharp, 1 slow rolloff
// - 16-bit word, bit15 zero, index 14:8
// - Phase bit 1 inverts analog output
// - Polarity bit selects zero flag active level
// - Grouping 0 gives independent left/right flags
// - Grouping 1: common flag right, left unassigned
// - Eight-level fourth-order delta-sigma modulator
// - Filter and modulator run at 64 fs
`timescale 1ns/1ns
module dacoc_top
   import dacoc_pkg::*;
(
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rstn,
   // Three-wire serial control port
   input wire logic ctl_latch_n,
   input wire logic ctl_clk,
   input wire logic ctl_data,
   // Audio samples at fs
   input wire logic signed [SAMPLE_W-1:0] sample_l,
   input wire logic signed [SAMPLE_W-1:0] sample_r,
   input wire logic sample_valid,
   // Zero flag pins
   output logic right_zero_flag_out,
   output logic left_zero_flag_out,
   output logic left_zero_flag_oe,
   // Modulator levels
   output logic [2:0] dac_level_l,
   output logic [2:0] dac_level_r
);

   logic [1:0] rst_sync;
   logic rst_n;
   logic [1:0] sync_latch;
   logic [1:0] sync_clk;
   logic [1:0] sync_data;
   logic prev_latch;
   logic prev_clk;
   logic latch_rise;
   logic latch_fall;
   logic clk_rise;
   dacoc_sp_state_t sp_state;
   logic [WORD_BITS-1:0] shift_word;
   logic [4:0] bit_cnt;
   logic commit;
   logic [WORD_BITS-1:0] commit_word;
   dacoc_opt_t opt;
   logic [7:0] os_cnt;
   logic os_tick;
   logic [1:0] zero_det;
   logic signed [SAMPLE_W-1:0] ch_in [2];
   logic [2:0] ch_level [2];

   function automatic logic word_hits(input logic [WORD_BITS-1:0] w, input logic [6:0] idx);
      word_hits = (w[IDX_MSB:IDX_LSB] == idx);
   endfunction : word_hits

   // Reset release through two flops
   always_ff @(posedge clk_sys or negedge rstn)
   begin
      if (!rstn)
         rst_sync <= 2'h0;
      else
         rst_sync <= {rst_sync[0], 1'b1};
   end
   assign rst_n = rst_sync[1];

   // Control pins are asynchronous to clk_sys
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         sync_latch <= 2'h3;
         sync_clk <= 2'h0;
         sync_data <= 2'h0;
         prev_latch <= 1'b1;
         prev_clk <= 1'b0;
      end
      else
      begin
         sync_latch <= {sync_latch[0], ctl_latch_n};
         sync_clk <= {sync_clk[0], ctl_clk};
         sync_data <= {sync_data[0], ctl_data};
         prev_latch <= sync_latch[1];
         prev_clk <= sync_clk[1];
      end
   end

   assign latch_rise = sync_latch[1] & ~prev_latch;
   assign latch_fall = ~sync_latch[1] & prev_latch;
   assign clk_rise = sync_clk[1] & ~prev_clk;

   // Word framed by the latch pin, MSB first on rising serial clock
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         sp_state <= SP_IDLE;
         shift_word <= 16'h0000;
         bit_cnt <= 5'h00;
         commit <= 1'b0;
         commit_word <= 16'h0000;
      end
      else
      begin
         commit <= 1'b0;
         case (sp_state)
            SP_IDLE:
            begin
               if (latch_fall)
               begin
                  shift_word <= 16'h0000;
                  bit_cnt <= 5'h00;
                  sp_state <= SP_SHIFT;
               end
            end
            SP_SHIFT:
            begin
               if (latch_rise)
               begin
                  // Short, long or bit-15-set words are dropped whole
                  if (bit_cnt == 5'h10 && !shift_word[WORD_ZERO_BIT])
                  begin
                     commit <= 1'b1;
                     commit_word <= shift_word;
                  end
                  sp_state <= SP_IDLE;
               end
               else if (clk_rise)
               begin
                  shift_word <= {shift_word[WORD_BITS-2:0], sync_data[1]};
                  if (bit_cnt != 5'h1f)
                     bit_cnt <= bit_cnt + 5'h01;
               end
            end
            default:
               sp_state <= SP_IDLE;
         endcase
      end
   end

   // Option register; soft reset shares the power-on values
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
         opt <= OPT_RESET;
      else if (commit)
      begin
         if (word_hits(commit_word, SOFT_RESET_IDX))
         begin
            if (commit_word[SOFT_RESET_BIT])
               opt <= OPT_RESET;
         end
         else if (word_hits(commit_word, FILTER_CTRL_IDX))
            opt.filter_rolloff_select <= commit_word[FILTER_ROLLOFF_BIT];
         else if (word_hits(commit_word, OUTPUT_OPT_IDX))
         begin
            opt.zero_flag_grouping <= commit_word[ZERO_GROUP_BIT];
            opt.zero_flag_polarity <= commit_word[ZERO_POL_BIT];
            opt.output_phase_invert <= commit_word[PHASE_INV_BIT];
         end
      end
   end

   // 64 fs oversample enable
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         os_cnt <= 8'h00;
         os_tick <= 1'b0;
      end
      else
      begin
         os_tick <= (os_cnt == OS_DIV_LAST);
         os_cnt <= (os_cnt == OS_DIV_LAST) ? 8'h00 : os_cnt + 8'h01;
      end
   end

   assign ch_in[0] = sample_l;
   assign ch_in[1] = sample_r;

   // Per channel: zero detect, interpolator, modulator
   for (genvar c = 0; c < 2; c++)
   begin : g_ch
      logic [10:0] zrun;
      logic signed [SAMPLE_W-1:0] held;
      logic signed [SAMPLE_W-1:0] interp;
      logic signed [SAMPLE_W:0] diff;

      always_ff @(posedge clk_sys or negedge rst_n)
      begin
         if (!rst_n)
         begin
            zrun <= 11'h000;
            zero_det[c] <= 1'b0;
         end
         else if (sample_valid)
         begin
            if (ch_in[c] == '0)
            begin
               if (zrun != ZERO_RUN)
                  zrun <= zrun + 11'h001;
               zero_det[c] <= (zrun >= ZERO_RUN - 11'h001);
            end
            else
            begin
               zrun <= 11'h000;
               zero_det[c] <= 1'b0;
            end
         end
      end

      // Slow rolloff trades stopband rejection for a gentler transient
      assign diff = {held[SAMPLE_W-1], held} - {interp[SAMPLE_W-1], interp};
      always_ff @(posedge clk_sys or negedge rst_n)
      begin
         if (!rst_n)
         begin
            held <= '0;
            interp <= '0;
         end
         else
         begin
            if (sample_valid)
               held <= ch_in[c];
            if (os_tick)
            begin
               if (opt.filter_rolloff_select)
                  interp <= interp + SAMPLE_W'(diff >>> 3);
               else
                  interp <= held;
            end
         end
      end

      dacoc_modulator u_mod (
         .clk_sys(clk_sys),
         .rst_n(rst_n),
         .os_tick(os_tick),
         .invert(opt.output_phase_invert),
         .din(interp),
         .level(ch_level[c])
      );
   end

   assign dac_level_l = ch_level[0];
   assign dac_level_r = ch_level[1];

   // Zero flag pins; left pin is released when grouped
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         right_zero_flag_out <= 1'b0;
         left_zero_flag_out <= 1'b0;
         left_zero_flag_oe <= 1'b1;
      end
      else
      begin
         if (opt.zero_flag_grouping)
            right_zero_flag_out <= (zero_det[0] & zero_det[1]) ^ opt.zero_flag_polarity;
         else
            right_zero_flag_out <= zero_det[1] ^ opt.zero_flag_polarity;
         left_zero_flag_out <= zero_det[0] ^ opt.zero_flag_polarity;
         left_zero_flag_oe <= ~opt.zero_flag_grouping;
      end
   end

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_n);

   property p_filter_write;
      commit && word_hits(commit_word, FILTER_CTRL_IDX)
      |=> opt.filter_rolloff_select == $past(commit_word[FILTER_ROLLOFF_BIT]);
   endproperty
   a_filter_write: assert property (p_filter_write)
      else $error("Filter select did not follow the control word");

   property p_bad_frame;
      sp_state == SP_SHIFT && latch_rise && bit_cnt != 5'h10 |=> !commit;
   endproperty
   a_bad_frame: assert property (p_bad_frame)
      else $error("Word of wrong length was accepted");

   property p_phase_write;
      commit && word_hits(commit_word, OUTPUT_OPT_IDX)
      |=> opt.output_phase_invert == $past(commit_word[PHASE_INV_BIT]);
   endproperty
   a_phase_write: assert property (p_phase_write)
      else $error("Phase select did not follow the control word");

   property p_left_polarity;
      1'b1 |=> left_zero_flag_out == ($past(zero_det[0]) ^ $past(opt.zero_flag_polarity));
   endproperty
   a_left_polarity: assert property (p_left_polarity)
      else $error("Left zero flag has wrong level");

   property p_independent;
      !opt.zero_flag_grouping
      |=> right_zero_flag_out == ($past(zero_det[1]) ^ $past(opt.zero_flag_polarity));
   endproperty
   a_independent: assert property (p_independent)
      else $error("Right zero flag wrong in independent mode");

   property p_grouped;
      opt.zero_flag_grouping |=> !left_zero_flag_oe
         && right_zero_flag_out == ($past(zero_det[0] & zero_det[1]) ^ $past(opt.zero_flag_polarity));
   endproperty
   a_grouped: assert property (p_grouped)
      else $error("Common zero flag wrong in grouped mode");

   property p_os_spacing;
      os_tick |=> (!os_tick)[*8] ##1 (!os_tick)[*7] ##1 os_tick;
   endproperty
   a_os_spacing: assert property (p_os_spacing)
      else $error("Oversample tick spacing is not sixteen cycles");

   property p_zero_clear;
      sample_valid && sample_l != '0 |=> !zero_det[0];
   endproperty
   a_zero_clear: assert property (p_zero_clear)
      else $error("Zero detect held after a nonzero sample");

   property p_soft_reset;
      commit && word_hits(commit_word, SOFT_RESET_IDX) && commit_word[SOFT_RESET_BIT]
      |=> opt == OPT_RESET;
   endproperty
   a_soft_reset: assert property (p_soft_reset)
      else $error("Soft reset left option bits changed");

   c_grouped: cover property (commit && word_hits(commit_word, OUTPUT_OPT_IDX)
                              && commit_word[ZERO_GROUP_BIT]);
   c_zero_seen: cover property (zero_det[0] && zero_det[1]);
   c_soft_reset: cover property (commit && commit_word[SOFT_RESET_BIT]
                                 && word_hits(commit_word, SOFT_RESET_IDX));

endmodule : dacoc_top

// file: bench/dacoc_host_model.sv
// Host controller model driving the three-wire serial control port
`timescale 1ns/1ns
module dacoc_host_model (
   // Clock
   input wire logic clk_sys,
   // Serial control port
   output logic ctl_latch_n,
   output logic ctl_clk,
   output logic ctl_data
);
   initial
   begin
      ctl_latch_n = 1'b1;
      ctl_clk = 1'b0;
      ctl_data = 1'b0;
   end

   task automatic hold(input int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask : hold

   // Sends the top nbits of w MSB first; a short count makes a refused frame
   task automatic send(input logic [15:0] w, input int nbits);
      ctl_latch_n = 1'b0;
      for (int i = 15; i > 15 - nbits; i--)
      begin
         ctl_data = w[i];
         hold(4);
         ctl_clk = 1'b1;
         hold(4);
         ctl_clk = 1'b0;
      end
      hold(4);
      ctl_latch_n = 1'b1;
      // Released line must not keep showing the last bit
      ctl_data = ~ctl_data;
      hold(4);
   endtask : send
endmodule : dacoc_host_model

// file: bench/dac_output_option_control_bench.sv
// Self-checking bench for the DAC output option control block
`timescale 1ns/1ns
`define CHECK(got, exp) \
   begin \
      checks++; \
      if ((got) !== (exp)) \
      begin \
         fail_count++; \
         $display("ERROR t=%0t got %h exp %h", $time, got, exp); \
      end \
   end
module dac_output_option_control_bench
   import dacoc_pkg::*;
;
   logic clk_sys = 1'b0;
   logic rstn = 1'b0;
   logic ctl_latch_n;
   logic ctl_clk;
   logic ctl_data;
   logic signed [SAMPLE_W-1:0] sample_l = '0;
   logic signed [SAMPLE_W-1:0] sample_r = '0;
   logic sample_valid = 1'b0;
   logic right_zero_flag_out;
   logic left_zero_flag_out;
   logic left_zero_flag_oe;
   logic [2:0] dac_level_l;
   logic [2:0] dac_level_r;
   int fail_count = 0;
   int checks = 0;
   int cycles = 0;
   int run_l = 0;
   int run_r = 0;
   logic [31:0] rng = 32'h0000_005F;
   dacoc_opt_t opt = OPT_RESET;

   always #10 clk_sys = ~clk_sys;

   dacoc_host_model host (
      .clk_sys(clk_sys),
      .ctl_latch_n(ctl_latch_n),
      .ctl_clk(ctl_clk),
      .ctl_data(ctl_data)
   );

   dacoc_top dut (
      .clk_sys(clk_sys),
      .rstn(rstn),
      .ctl_latch_n(ctl_latch_n),
      .ctl_clk(ctl_clk),
      .ctl_data(ctl_data),
      .sample_l(sample_l),
      .sample_r(sample_r),
      .sample_valid(sample_valid),
      .right_zero_flag_out(right_zero_flag_out),
      .left_zero_flag_out(left_zero_flag_out),
      .left_zero_flag_oe(left_zero_flag_oe),
      .dac_level_l(dac_level_l),
      .dac_level_r(dac_level_r)
   );

   task automatic print_verdict();
      $display("checks %0d mismatches %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : print_verdict

   always @(posedge clk_sys)
   begin
      cycles++;
      if (cycles == 40000)
      begin
         fail_count++;
         $display("ERROR t=%0t timeout", $time);
         print_verdict();
      end
   end

   // Never zero, so a random sample always breaks a zero run
   function automatic logic signed [SAMPLE_W-1:0] rnd();
      rng ^= rng << 13;
      rng ^= rng >> 17;
      rng ^= rng << 5;
      return SAMPLE_W'(rng | 32'h0000_0001);
   endfunction : rnd

   task automatic check_flags();
      logic dl;
      logic dr;
      dl = run_l >= int'(ZERO_RUN);
      dr = run_r >= int'(ZERO_RUN);
      if (opt.zero_flag_grouping)
         `CHECK(right_zero_flag_out, (dl & dr) ^ opt.zero_flag_polarity)
      else
         `CHECK(right_zero_flag_out, dr ^ opt.zero_flag_polarity)
      `CHECK(left_zero_flag_oe, ~opt.zero_flag_grouping)
      if (!opt.zero_flag_grouping)
         `CHECK(left_zero_flag_out, dl ^ opt.zero_flag_polarity)
   endtask : check_flags

   task automatic push(input logic signed [SAMPLE_W-1:0] l, input logic signed [SAMPLE_W-1:0] r);
      sample_l = l;
      sample_r = r;
      sample_valid = 1'b1;
      run_l = (l == 0) ? run_l + 1 : 0;
      run_r = (r == 0) ? run_r + 1 : 0;
      @(posedge clk_sys);
      #1;
      sample_valid = 1'b0;
      repeat (3) @(posedge clk_sys);
      #1;
      check_flags();
   endtask : push

   task automatic wr(input logic [15:0] w, input int nb);
      host.send(w, nb);
      repeat (4) @(posedge clk_sys);
      #1;
      if (nb == WORD_BITS && !w[15])
      begin
         if (w[14:8] == OUTPUT_OPT_IDX)
            {opt.zero_flag_grouping, opt.zero_flag_polarity, opt.output_phase_invert} = w[2:0];
         if (w[14:8] == FILTER_CTRL_IDX)
            opt.filter_rolloff_select = w[5];
         if (w[14:8] == SOFT_RESET_IDX && w[7])
            opt = OPT_RESET;
      end
      check_flags();
   endtask : wr

   task automatic bias(input logic exp_hi);
      int sum;
      sum = 0;
      // Modulator step response needs about thirty ticks to settle
      repeat (128) push(24'sh40_0000, 24'sh40_0000);
      repeat (64)
      begin
         push(24'sh40_0000, 24'sh40_0000);
         sum += dac_level_l + dac_level_r;
      end
      `CHECK(sum > 512, exp_hi)
      $display("test bias done");
   endtask : bias

   initial
   begin
      repeat (2) @(posedge clk_sys);
      #1;
      `CHECK({right_zero_flag_out, left_zero_flag_oe}, 2'h1)
      `CHECK({dac_level_l, dac_level_r}, 6'h24)
      @(posedge clk_sys);
      #1;
      rstn = 1'b1;
      repeat (6) @(posedge clk_sys);
      #1;
      check_flags();
      $display("test reset done");
      // Right only, left only, then both detected; each mode code in each state
      for (int s = 0; s < 3; s++)
      begin
         repeat (1024) push(s == 0 ? rnd() : '0, s == 1 ? rnd() : '0);
         for (int m = 0; m < 8; m++)
            wr({1'b0, OUTPUT_OPT_IDX, 8'(m)}, 16);
         wr({1'b0, OUTPUT_OPT_IDX, 8'h00}, 16);
         $display("test zero state %0d done", s);
      end
      push(rnd(), rnd());
      wr({1'b0, OUTPUT_OPT_IDX, 8'h02}, 16);
      wr({1'b1, OUTPUT_OPT_IDX, 8'h04}, 16);
      wr({1'b0, OUTPUT_OPT_IDX, 8'h04}, 15);
      wr({1'b0, 7'h15, 8'hFF}, 16);
      wr({1'b0, SOFT_RESET_IDX, 8'h7F}, 16);
      wr({1'b0, SOFT_RESET_IDX, 8'h80}, 16);
      $display("test refusal done");
      bias(1'b1);
      wr({1'b0, OUTPUT_OPT_IDX, 8'h01}, 16);
      bias(1'b0);
      wr({1'b0, FILTER_CTRL_IDX, 8'h20}, 16);
      bias(1'b0);
      wr({1'b0, SOFT_RESET_IDX, 8'h80}, 16);
      bias(1'b1);
      print_verdict();
   end
endmodule : dac_output_option_control_bench
